// ===== logic/epwm_params.svh
`ifndef EPWM_PARAMS_SVH
`define EPWM_PARAMS_SVH

// ********************************************************************
// Clocking
// ********************************************************************
`define CLK_SYS_HZ       40000000
`define INSTR_CLK_DIV    4

// ********************************************************************
// Control field encodings and positions
// ********************************************************************
`define UNIT_CTRL_RESET  8'h00
`define CCP_PWM_MODE     2'h3
`define MODE_SINGLE      2'h0
`define MODE_HALF        2'h2
`define POL_A_LOW_BIT    1
`define POL_B_LOW_BIT    0
`define SRC_CMP_BIT      0
`define SRC_INT_BIT      2
`define SD_DRIVE_LOW     2'h0
`define SD_DRIVE_HIGH    2'h1
`define SD_TRISTATE_BIT  1
`define DEADBAND_W       7

`endif

// ===== logic/epwm_pkg.sv
`default_nettype none

package epwm_pkg;

  // ********************************************************************
  // Configuration carriers, pin drive and generator state
  // ********************************************************************
  typedef struct packed {
    logic [1:0] output_mode_select;
    logic [1:0] duty_low_bits;
    logic [3:0] unit_mode_polarity_bits;
  } unit_ctrl_t;

  typedef struct packed {
    logic [2:0] shutdown_source_select;
    logic [1:0] pair_a_shutdown_state;
    logic [1:0] pair_b_shutdown_state;
  } shutdown_cfg_t;

  typedef struct packed {
    logic       auto_restart_enable;
    logic [6:0] deadband_count;
  } deadband_cfg_t;

  typedef struct packed {
    logic pwm_out_a;
    logic pwm_out_a_oe;
    logic pwm_out_b;
    logic pwm_out_b_oe;
  } pin_drive_t;

  typedef enum logic [1:0] {
    GEN_OFF,
    GEN_ARM,
    GEN_FIRST,
    GEN_RUN
  } gen_state_t;

endpackage

`default_nettype wire

// ===== logic/deadband_delay.sv
`default_nettype none
`include "epwm_params.svh"

module deadband_delay
  import epwm_pkg::*;
#(
  parameter int CNT_W = `DEADBAND_W
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_n,
  input  wire logic             instr_tick,
  input  wire logic             req_active,
  input  wire logic [CNT_W-1:0] delay_count,
  output var  logic             out_active
);

  // ********************************************************************
  // Turn-on delay
  // ********************************************************************
  logic             req_q;
  logic [CNT_W-1:0] remaining;

  wire             rise = req_active & ~req_q;
  wire             done = (remaining == '0);
  wire [CNT_W-1:0] dec_remaining = (instr_tick && !done) ? remaining - 1'b1 : remaining;
  wire [CNT_W-1:0] next_remaining = !req_active ? '0 :
                                    rise        ? delay_count :
                                                  dec_remaining;
  // A request that ends before the count runs out never turns active
  wire             next_active = req_active & (next_remaining == '0);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      req_q      <= 1'b0;
      remaining  <= '0;
      out_active <= 1'b0;
    end else begin
      req_q      <= req_active;
      remaining  <= next_remaining;
      out_active <= next_active;
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  a_delay_holds: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (rise && delay_count != '0) |=> !out_active)
    else $error("output turned active before dead-band elapsed");

  a_delay_expires: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    (req_active && !rise && remaining == CNT_W'(1) && instr_tick) |=> out_active)
    else $error("output not active when dead-band ran out");

  a_short_pulse_off: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    !req_active |=> !out_active)
    else $error("output active without a request");

  a_restart_count: assert property (
    @(posedge clk_sys) disable iff (!rst_n)
    rise |=> remaining == $past(delay_count))
    else $error("dead-band counter not reloaded on transition");

endmodule

`default_nettype wire

// ===== logic/enhanced_pwm_output_stage.sv
`default_nettype none
`include "epwm_params.svh"


module enhanced_pwm_output_stage
  import epwm_pkg::*;
#(
  parameter int INSTR_DIV = `INSTR_CLK_DIV
) (
  input  wire logic          clk_sys,
  input  wire logic          rst_n,
  input  wire unit_ctrl_t    unit_ctrl,
  input  wire shutdown_cfg_t shutdown_cfg,
  input  wire deadband_cfg_t deadband_cfg,
  input  wire logic          pwm_raw,
  input  wire logic          period_start,
  input  wire logic          int_pin_level,
  input  wire logic          comparator_event,
  input  wire logic          status_write,
  input  wire logic          status_write_value,
  input  wire logic          flag_clear,
  input  wire logic          port_latch_a,
  input  wire logic          port_latch_b,
  input  wire logic          pin_direction_bit_a,
  input  wire logic          pin_direction_bit_b,
  output var  pin_drive_t    pin_drive,
  output var  logic          shutdown_status_bit,
  output var  logic          base_timer_match_flag
);

  localparam int DIV_W = $clog2(INSTR_DIV);

  // ********************************************************************
  // Pin selection
  // ********************************************************************
  // Returns {level, enable}. A set direction bit always wins, so firmware
  // keeps the final say over the driver even during shutdown.
  function automatic logic [1:0] pin_next(
    input logic       own,
    input logic       sd,
    input logic [1:0] sd_state,
    input logic       act,
    input logic       pol_low,
    input logic       latch,
    input logic       dir
  );
    logic drv;
    drv = ~dir;
    if (!own) begin
      pin_next = {latch, drv};
    end else if (sd) begin
      pin_next = {sd_state == `SD_DRIVE_HIGH,
                  drv & ~sd_state[`SD_TRISTATE_BIT]};
    end else begin
      pin_next = {act ^ pol_low, drv};
    end
  endfunction

  // ********************************************************************
  // Mode decode
  // ********************************************************************
  wire pwm_sel     = unit_ctrl.unit_mode_polarity_bits[3:2] == `CCP_PWM_MODE;
  wire ctrl_zero   = unit_ctrl == `UNIT_CTRL_RESET;
  wire half_mode   = unit_ctrl.output_mode_select == `MODE_HALF;
  wire single_mode = unit_ctrl.output_mode_select == `MODE_SINGLE;
  wire enabled     = pwm_sel & ~ctrl_zero & (half_mode | single_mode);
  wire own_a       = enabled;
  wire own_b       = enabled & half_mode;
  wire pol_a_low   = unit_ctrl.unit_mode_polarity_bits[`POL_A_LOW_BIT];
  wire pol_b_low   = unit_ctrl.unit_mode_polarity_bits[`POL_B_LOW_BIT];

  // ********************************************************************
  // Instruction-cycle divider
  // ********************************************************************
  // Free running; the dead-band start therefore lands anywhere inside an
  // instruction cycle, which costs up to one cycle of jitter on turn-on.
  logic [DIV_W-1:0] div_cnt;

  wire             instr_tick   = div_cnt == DIV_W'(INSTR_DIV - 1);
  wire [DIV_W-1:0] next_div_cnt = instr_tick ? '0 : div_cnt + 1'b1;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      div_cnt <= '0;
    end else begin
      div_cnt <= next_div_cnt;
    end
  end

  // ********************************************************************
  // Auto-shutdown
  // ********************************************************************
  wire src_cmp = shutdown_cfg.shutdown_source_select[`SRC_CMP_BIT] & comparator_event;
  wire src_int = shutdown_cfg.shutdown_source_select[`SRC_INT_BIT] & ~int_pin_level;
  wire source_hit = src_cmp | src_int;
  wire fw_set     = status_write & status_write_value;
  wire restart    = deadband_cfg.auto_restart_enable & shutdown_status_bit;

  // Source level wins over any write, so a live condition cannot be cleared
  wire next_status = source_hit   ? 1'b1 :
                     status_write ? status_write_value :
                     restart      ? 1'b0 :
                                    shutdown_status_bit;

  // Pins follow the raw condition or a firmware set in the same cycle, and the stored bit after that
  wire shutdown_now = source_hit | fw_set | shutdown_status_bit;

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      shutdown_status_bit <= 1'b0;
    end else begin
      shutdown_status_bit <= next_status;
    end
  end

  // ********************************************************************
  // Generation gate
  // ********************************************************************
  gen_state_t gen_state;
  gen_state_t next_gen_state;

  always_comb begin
    next_gen_state = gen_state;
    case (gen_state)
      GEN_OFF: begin
        if (enabled) begin
          next_gen_state = GEN_ARM;
        end
      end
      GEN_ARM: begin
        if (period_start && !shutdown_now) begin
          next_gen_state = GEN_FIRST;
        end
      end
      GEN_FIRST: begin
        if (period_start) begin
          next_gen_state = GEN_RUN;
        end
      end
      GEN_RUN: begin
        next_gen_state = GEN_RUN;
      end
      default: begin
        next_gen_state = GEN_OFF;
      end
    endcase
    if (!enabled) begin
      next_gen_state = GEN_OFF;
    end else if (shutdown_now && gen_state != GEN_OFF) begin
      next_gen_state = GEN_ARM;
    end
  end

  wire armed_go = gen_state == GEN_ARM && period_start && !shutdown_now;
  wire gen_on   = gen_state == GEN_FIRST || gen_state == GEN_RUN || armed_go;
  wire req_a    = gen_on & pwm_raw;
  wire req_b    = gen_on & half_mode & ~pwm_raw;

  // Single mode runs without dead-band
  wire [`DEADBAND_W-1:0] dly = half_mode ? deadband_cfg.deadband_count : '0;

  // Flag marks the start of the second period and every one after it
  wire flag_set = period_start && (gen_state == GEN_FIRST || gen_state == GEN_RUN);
  wire next_flag = flag_set | (base_timer_match_flag & ~flag_clear);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      gen_state             <= GEN_OFF;
      base_timer_match_flag <= 1'b0;
    end else begin
      gen_state             <= next_gen_state;
      base_timer_match_flag <= next_flag;
    end
  end

  // ********************************************************************
  // Dead-band and output pins
  // ********************************************************************
  logic act_a;
  logic act_b;

  deadband_delay #(
    .CNT_W(`DEADBAND_W)
  ) u_delay_a (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .instr_tick (instr_tick),
    .req_active (req_a),
    .delay_count(dly),
    .out_active (act_a)
  );

  deadband_delay #(
    .CNT_W(`DEADBAND_W)
  ) u_delay_b (
    .clk_sys    (clk_sys),
    .rst_n      (rst_n),
    .instr_tick (instr_tick),
    .req_active (req_b),
    .delay_count(dly),
    .out_active (act_b)
  );

  wire [1:0] next_pin_a = pin_next(own_a, shutdown_now,
                                   shutdown_cfg.pair_a_shutdown_state,
                                   act_a, pol_a_low, port_latch_a, pin_direction_bit_a);
  wire [1:0] next_pin_b = pin_next(own_b, shutdown_now,
                                   shutdown_cfg.pair_b_shutdown_state,
                                   act_b, pol_b_low, port_latch_b, pin_direction_bit_b);

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      pin_drive <= '0;
    end else begin
      pin_drive <= {next_pin_a, next_pin_b};
    end
  end

  // ********************************************************************
  // Checks
  // ********************************************************************
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);

  sequence armed_wait;
    gen_state == GEN_ARM && !period_start;
  endsequence

  sequence first_period_end;
    gen_state == GEN_FIRST && period_start;
  endsequence

  sequence tick_gap;
    !instr_tick [*3] ##1 instr_tick;
  endsequence

  a_reset_pins_off: assert property (
    @(posedge clk_sys) disable iff (1'b0)
    !rst_n |=> !pin_drive.pwm_out_a_oe && !pin_drive.pwm_out_b_oe)
    else $error("pin driver enabled after reset");

  a_release_on_zero: assert property (
    ctrl_zero |=> pin_drive.pwm_out_a == $past(port_latch_a)
               && pin_drive.pwm_out_a_oe == !$past(pin_direction_bit_a))
    else $error("pin A not handed back to port logic");

  a_single_b_free: assert property (
    (enabled && single_mode) |=> pin_drive.pwm_out_b == $past(port_latch_b)
                              && pin_drive.pwm_out_b_oe == !$past(pin_direction_bit_b))
    else $error("pin B taken in single mode");

  a_hold_partial: assert property (
    armed_wait |-> !req_a && !req_b)
    else $error("waveform generated before period start");

  a_flag_second: assert property (
    first_period_end |=> base_timer_match_flag)
    else $error("match flag not set at second period");

  a_no_overlap: assert property (
    !(act_a && act_b) and (gen_on && half_mode |-> req_a != req_b))
    else $error("half-bridge outputs not complementary");

  a_status_set: assert property (
    source_hit |=> shutdown_status_bit [*1] ##1 (shutdown_status_bit || !$past(source_hit)))
    else $error("shutdown source did not set status");

  a_status_sticky: assert property (
    (shutdown_status_bit && !status_write && !deadband_cfg.auto_restart_enable)
    |=> shutdown_status_bit)
    else $error("status cleared without firmware");

  a_write_ignored: assert property (
    (source_hit && status_write && !status_write_value) |=> shutdown_status_bit)
    else $error("status write honoured during shutdown condition");

  a_auto_restart: assert property (
    (restart && !source_hit && !status_write) |=> !shutdown_status_bit)
    else $error("auto-restart did not clear status");

  a_sd_drive_low: assert property (
    (own_a && source_hit && !pin_direction_bit_a
     && shutdown_cfg.pair_a_shutdown_state == `SD_DRIVE_LOW)
    |=> pin_drive.pwm_out_a_oe && !pin_drive.pwm_out_a)
    else $error("pin A not driven low in shutdown");

  a_sd_tristate: assert property (
    (own_b && shutdown_now && shutdown_cfg.pair_b_shutdown_state[`SD_TRISTATE_BIT])
    |=> !pin_drive.pwm_out_b_oe)
    else $error("pin B driven while shutdown asks for high-Z");

  a_tick_spacing: assert property (
    instr_tick |=> tick_gap)
    else $error("instruction tick spacing wrong");

endmodule

`default_nettype wire

// ===== bench/bridge_model.sv
`default_nettype none

// ********************************************************************
// Half-bridge switch pair seen from the two output pins
// ********************************************************************
module bridge_model
  import epwm_pkg::*;
(
  input  wire pin_drive_t pin_drive,
  output var  logic       level_a,
  output var  logic       level_b
);
  timeunit 1ns;
  timeprecision 1ps;

  // A released pin is pulled low so that its switch stays off
  always_comb begin
    level_a = pin_drive.pwm_out_a_oe ? pin_drive.pwm_out_a : 1'b0;
    level_b = pin_drive.pwm_out_b_oe ? pin_drive.pwm_out_b : 1'b0;
  end
endmodule

`default_nettype wire

// ===== bench/tb.sv
`default_nettype none

module tb
  import epwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int PER = 48;

  logic          clk_sys;
  logic          rst_n              = 1'b0;
  unit_ctrl_t    unit_ctrl          = 8'h8c;
  shutdown_cfg_t shutdown_cfg       = '0;
  deadband_cfg_t deadband_cfg       = '0;
  logic          pwm_raw            = 1'b0;
  logic          period_start       = 1'b0;
  logic          int_pin_level      = 1'b1;
  logic          comparator_event   = 1'b0;
  logic          status_write       = 1'b0;
  logic          status_write_value = 1'b0;
  logic          flag_clear         = 1'b0;
  logic          port_latch_a       = 1'b0;
  logic          port_latch_b       = 1'b0;
  logic          dir_a              = 1'b0;
  logic          dir_b              = 1'b0;
  pin_drive_t    pin_drive;
  logic          shutdown_status_bit;
  logic          base_timer_match_flag;
  logic          level_a;
  logic          level_b;
  logic          hit;
  int            pcnt       = 0;
  int            duty       = 16;
  int            cycles     = 0;
  int            errors     = 0;
  int            num_checks = 0;
  int            ca, cb, ov, n, ea, eb, cnt;

  enhanced_pwm_output_stage u_dut (
    .clk_sys(clk_sys), .rst_n(rst_n), .unit_ctrl(unit_ctrl),
    .shutdown_cfg(shutdown_cfg), .deadband_cfg(deadband_cfg),
    .pwm_raw(pwm_raw), .period_start(period_start),
    .int_pin_level(int_pin_level), .comparator_event(comparator_event),
    .status_write(status_write), .status_write_value(status_write_value),
    .flag_clear(flag_clear), .port_latch_a(port_latch_a),
    .port_latch_b(port_latch_b), .pin_direction_bit_a(dir_a),
    .pin_direction_bit_b(dir_b), .pin_drive(pin_drive),
    .shutdown_status_bit(shutdown_status_bit),
    .base_timer_match_flag(base_timer_match_flag)
  );

  bridge_model u_bridge (.pin_drive(pin_drive), .level_a(level_a), .level_b(level_b));

  initial begin
    clk_sys = 1'b0;
    forever #12.5 clk_sys = ~clk_sys;
  end

  // ********************************************************************
  // Base timer stand-in: free-running period with a start pulse
  // ********************************************************************
  always @(negedge clk_sys) begin
    pcnt <= (pcnt + 1) % PER;
    period_start <= ((pcnt + 1) % PER) == 0;
    pwm_raw <= ((pcnt + 1) % PER) < duty;
  end

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      stop_test();
    end
  end

  // ********************************************************************
  // Helpers
  // ********************************************************************
  task automatic stop_test();
    $display("Checks %0d mismatches %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Undriven pin values are masked: only driven levels matter
  function automatic logic [3:0] drv(pin_drive_t p);
    return {p.pwm_out_a & p.pwm_out_a_oe, p.pwm_out_a_oe,
            p.pwm_out_b & p.pwm_out_b_oe, p.pwm_out_b_oe};
  endfunction

  function automatic logic [3:0] sd_pins(shutdown_cfg_t c);
    return {c.pair_a_shutdown_state == 2'b01, ~c.pair_a_shutdown_state[1],
            c.pair_b_shutdown_state == 2'b01, ~c.pair_b_shutdown_state[1]};
  endfunction

  task automatic tick(input int k);
    repeat (k) @(negedge clk_sys);
  endtask

  task automatic wait_start();
    do @(negedge clk_sys); while (!period_start);
  endtask

  task automatic fw_write(input logic v);
    status_write = 1'b1;
    status_write_value = v;
    tick(1);
    status_write = 1'b0;
    tick(1);
  endtask

  // Drivers off, mode and polarity set, two full periods, then drivers on
  task automatic enable(input unit_ctrl_t c, input deadband_cfg_t d);
    dir_a = 1'b1;
    dir_b = 1'b1;
    unit_ctrl = '0;
    wait_start();
    unit_ctrl = c;
    deadband_cfg = d;
    flag_clear = 1'b1;
    tick(1);
    flag_clear = 1'b0;
    tick(1);
    check("flag cleared", 8'(base_timer_match_flag), 8'h00);
    wait_start();
    check("flag first period", 8'(base_timer_match_flag), 8'h00);
    wait_start();
    check("flag second period", 8'(base_timer_match_flag), 8'h01);
    dir_a = 1'b0;
    dir_b = 1'b0;
    tick(4);
  endtask

  task automatic measure();
    logic a, b;
    ca = 0;
    cb = 0;
    ov = 0;
    repeat (PER) begin
      @(negedge clk_sys);
      a = pin_drive.pwm_out_a ^ unit_ctrl.unit_mode_polarity_bits[1];
      b = pin_drive.pwm_out_b ^ unit_ctrl.unit_mode_polarity_bits[0];
      ca += a;
      cb += b;
      ov += a & b;
    end
  endtask

  // ********************************************************************
  // Main sequence
  // ********************************************************************
  initial begin
    void'($urandom(99));
    tick(8);
    check("pins in reset", 8'(drv(pin_drive)), 8'h00);
    check("status in reset", 8'(shutdown_status_bit), 8'h00);
    tick(8);
    rst_n = 1'b1;
    $display("Test reset done");
    for (int k = 0; k < 8; k++) begin
      unit_ctrl = k[0] ? 8'h4c : 8'h00;
      {port_latch_a, port_latch_b, dir_a, dir_b} = 4'($urandom());
      tick(2);
      check("port pins", 8'(drv(pin_drive)), 8'({port_latch_a & ~dir_a, ~dir_a,
            port_latch_b & ~dir_b, ~dir_b}));
    end
    $display("Test port release done");
    for (int p = 0; p < 2; p++) begin
      duty = 8 + $urandom_range(12);
      enable({2'b00, 2'($urandom()), 2'b11, p[0], 1'b0}, '0);
      measure();
      check("single width", 8'(ca), 8'(duty));
      check("pin b port", 8'(drv(pin_drive) & 4'h3), 8'({port_latch_b, 1'b1}));
    end
    $display("Test single mode done");
    for (int k = 0; k < 4; k++) begin
      n = (k == 1) ? 1 + $urandom_range(2) : (k == 2) ? 20 : 0;
      duty = 14 + $urandom_range(10);
      enable({2'b10, 2'b00, 2'b11, k == 3, k == 3}, {1'b0, 7'(n)});
      measure();
      ea = duty - 4 * n;
      eb = PER - duty - 4 * n;
      if (k == 2) begin
        check("long dead-band", 8'(ca + cb), 8'h00);
      end else begin
        check("width a", 8'(ca >= ea - 1 && ca <= ea + 4), 8'h01);
        check("width b", 8'(cb >= eb - 1 && cb <= eb + 4), 8'h01);
      end
      check("no overlap", 8'(ov), 8'h00);
    end
    $display("Test half-bridge done");
    enable(8'h8c, '0);
    for (int k = 0; k < 16; k++) begin
      shutdown_cfg = (k == 0) ? 7'h50 : 7'($urandom());
      {int_pin_level, comparator_event} = (k == 0) ? 2'b01 : 2'($urandom());
      hit = (shutdown_cfg.shutdown_source_select[0] & comparator_event) |
            (shutdown_cfg.shutdown_source_select[2] & ~int_pin_level);
      tick(2);
      check("status", 8'(shutdown_status_bit), 8'(hit));
      if (hit) begin
        check("shutdown pins", 8'(drv(pin_drive)), 8'(sd_pins(shutdown_cfg)));
        check("load level", 8'({level_a, level_b}), 8'({sd_pins(shutdown_cfg)[3],
              sd_pins(shutdown_cfg)[1]}));
        fw_write(1'b0);
        check("write ignored", 8'(shutdown_status_bit), 8'h01);
        int_pin_level = 1'b1;
        comparator_event = 1'b0;
        wait_start();
        check("status held", 8'(shutdown_status_bit), 8'h01);
        fw_write(1'b0);
        check("firmware clear", 8'(shutdown_status_bit), 8'h00);
        tick(1);
        cnt = 0;
        while (!period_start) begin
          cnt += pin_drive.pwm_out_a | pin_drive.pwm_out_b;
          tick(1);
        end
        check("resume at start", 8'(cnt), 8'h00);
      end
    end
    int_pin_level = 1'b1;
    comparator_event = 1'b0;
    shutdown_cfg = 7'h10;
    fw_write(1'b1);
    check("firmware set", 8'(shutdown_status_bit), 8'h01);
    fw_write(1'b0);
    check("firmware reset", 8'(shutdown_status_bit), 8'h00);
    deadband_cfg = 8'h80;
    comparator_event = 1'b1;
    tick(2);
    check("auto held", 8'(shutdown_status_bit), 8'h01);
    comparator_event = 1'b0;
    tick(3);
    check("auto cleared", 8'(shutdown_status_bit), 8'h00);
    $display("Test shutdown done");
    stop_test();
  end
endmodule

`default_nettype wire
